// >>> shared/awpc_defs.svh
`ifndef AWPC_DEFS_SVH
`define AWPC_DEFS_SVH

// Register offsets.
`define AWPC_OFF_KEY_INDEX   8'he1
`define AWPC_OFF_KEY_DATA    8'he2
`define AWPC_OFF_STATUS      8'he3
`define AWPC_OFF_CONTROL     8'he4
`define AWPC_OFF_RST_SOURCE  8'he5
`define AWPC_OFF_LAST_STATE  8'he6

// Reset values and writable masks.
`define AWPC_RST_KEY_INDEX   8'h00
`define AWPC_RST_KEY_BYTE    8'hff
`define AWPC_RST_STATUS      8'h08
`define AWPC_RST_CONTROL     8'h00
`define AWPC_RST_SOURCE      8'h00
`define AWPC_MASK_CONTROL    8'hfc
`define AWPC_MASK_SOURCE     8'h1d
`define AWPC_MASK_LAST_STATE 8'h10

// Field positions.
`define AWPC_ST_STANDBY      5
`define AWPC_ST_DECISION     4
`define AWPC_ST_THERMAL      3
`define AWPC_ST_PANEL        2
`define AWPC_ST_MOUSE        1
`define AWPC_ST_KEYBOARD     0
`define AWPC_CT_OFF_PULSE    7
`define AWPC_CT_POLICY_HI    6
`define AWPC_CT_POLICY_LO    5
`define AWPC_CT_GATE_EN      4
`define AWPC_CT_ANY_KEY      3
`define AWPC_CT_HUNT         2
`define AWPC_RS_VID          4
`define AWPC_RS_GPIO_B       3
`define AWPC_RS_GPIO_A       2
`define AWPC_RS_SUPPLY_DIS   0
`define AWPC_LS_FLAG         4

// Index windows onto the key store.
`define AWPC_IDX_SET0        4'h0
`define AWPC_IDX_CAPTURE     4'h1
`define AWPC_IDX_SET1        4'h3
`define AWPC_IDX_SET2        4'h4
`define AWPC_IDX_LAST        4'he
`define AWPC_KEY_BYTES       15
`define AWPC_KEY_SETS        3

// Off pulse on return from power loss.
`define AWPC_OFF_PULSE_MS    4000
`define AWPC_CLK_KHZ         25000
`define AWPC_OFF_PULSE_CYCLES (`AWPC_OFF_PULSE_MS * `AWPC_CLK_KHZ)

`endif

// >>> shared/awpc_pkg.sv
`include "awpc_defs.svh"

package awpc_pkg;

    typedef enum logic [2:0] {
        AWPC_REG_SET0,
        AWPC_REG_SET1,
        AWPC_REG_SET2,
        AWPC_REG_CAPTURE,
        AWPC_REG_NONE
    } awpc_region_t;

    typedef enum logic [1:0] {
        AWPC_POL_OFF,
        AWPC_POL_ON,
        AWPC_POL_PRIOR,
        AWPC_POL_USER
    } awpc_policy_t;

    typedef struct packed {
        logic standby_cycled;
        logic thermal;
        logic panel_switch_in;
        logic mouse_wake;
    } awpc_evt_t;

endpackage

// >>> verilog/awpc_ctrl.sv
// The implementer's own choice: the address-and-strobe port.
`include "awpc_defs.svh"

module awpc_ctrl
    import awpc_pkg::*;
#(
    parameter int unsigned OFF_PULSE_CYCLES = `AWPC_OFF_PULSE_CYCLES
) (
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic       HOST_RST_N,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       KEY_VALID,
    input  wire logic [7:0] KEY_BYTE,
    input  wire awpc_evt_t  EVT,
    input  wire logic       POWER_RETURN,
    input  wire logic       SYSTEM_WAS_ON,
    input  wire logic       SUPPLY_GOOD_IN,
    input  wire logic       POWER_GOOD_IN,
    output logic            POWER_SWITCH_OUT_N,
    output logic            STANDBY_GATE_N,
    output logic            POWER_GOOD_OUT,
    output logic            POWER_GOOD_OUT_SECOND,
    output logic            VOLTAGE_ID_RST_N,
    output logic            GPIO_A_RST_N,
    output logic            GPIO_B_RST_N,
    output logic            WAKE_REQ
);

    localparam int CW = $clog2(OFF_PULSE_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]    index_reg;
    logic [7:0]    status_reg;
    logic [7:0]    status_next;
    logic [7:0]    control_reg;
    logic [7:0]    source_reg;
    logic [7:0]    last_state_reg;
    logic [7:0]    rdata_reg;
    logic [7:0]    rd_value;
    logic [7:0]    key_mem_reg [0:`AWPC_KEY_SETS*16-1];
    logic [7:0]    capture_reg [0:`AWPC_KEY_BYTES-1];
    logic          key_seen_reg;
    logic          panel_prev_reg;
    logic          power_switch_out_n_n_reg;
    logic          gate_n_reg;
    logic          pgood_reg;
    logic          vid_rst_n_reg;
    logic          gpa_rst_n_reg;
    logic          gpb_rst_n_reg;
    logic          wake_reg;
    logic [CW-1:0] pulse_cnt_reg;
    awpc_region_t  region;
    logic          wr_index;
    logic          wr_data;
    logic          rd_status;
    logic          panel_evt;
    logic          kb_evt;
    logic          wake_evt;
    logic          decide_off;
    logic          pulse_start;

    ////////////////////////////////////////////////////////////////////////
    function automatic awpc_region_t region_of(input logic [7:0] idx);
        awpc_region_t r;
        r = AWPC_REG_NONE;
        if (idx[3:0] > `AWPC_IDX_LAST) begin
            r = AWPC_REG_NONE;
        end else if (idx[7:4] == `AWPC_IDX_SET0) begin
            r = AWPC_REG_SET0;
        end else if (idx[7:4] == `AWPC_IDX_SET1) begin
            r = AWPC_REG_SET1;
        end else if (idx[7:4] == `AWPC_IDX_SET2) begin
            r = AWPC_REG_SET2;
        end else if (idx[7:4] == `AWPC_IDX_CAPTURE) begin
            r = AWPC_REG_CAPTURE;
        end
        return r;
    endfunction

    function automatic logic [5:0] mem_addr(input awpc_region_t r, input logic [3:0] lo);
        logic [1:0] set;
        set = 2'd0;
        case (r)
            AWPC_REG_SET1: set = 2'd1;
            AWPC_REG_SET2: set = 2'd2;
            default:       set = 2'd0;
        endcase
        return {set, lo};
    endfunction

    // Zero bytes act as wildcards, so a short sequence may be stored.
    function automatic logic set_match(input logic [1:0] set);
        logic hit;
        logic any;
        logic [7:0] s;
        hit = 1'b1;
        any = 1'b0;
        s   = 8'h00;
        for (int i = 0; i < `AWPC_KEY_BYTES; i++) begin
            s = key_mem_reg[{set, i[3:0]}];
            if (s != 8'h00) begin
                any = 1'b1;
                if (s != capture_reg[i]) begin
                    hit = 1'b0;
                end
            end
        end
        return hit && any;
    endfunction

    function automatic logic off_decision(input awpc_policy_t pol, input logic was_on,
                                          input logic flag);
        logic off;
        off = 1'b1;
        case (pol)
            AWPC_POL_OFF:   off = 1'b1;
            AWPC_POL_ON:    off = 1'b0;
            AWPC_POL_PRIOR: off = ~was_on;
            AWPC_POL_USER:  off = flag;
            default:        off = 1'b1;
        endcase
        return off;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    assign region    = region_of(index_reg);
    assign wr_index  = WR && (ADDR == `AWPC_OFF_KEY_INDEX);
    assign wr_data   = WR && (ADDR == `AWPC_OFF_KEY_DATA);
    assign rd_status = RD && (ADDR == `AWPC_OFF_STATUS);
    assign panel_evt = EVT.panel_switch_in && !panel_prev_reg;
    assign kb_evt    = key_seen_reg && (control_reg[`AWPC_CT_ANY_KEY] ||
                       set_match(2'd0) || set_match(2'd1) || set_match(2'd2));
    assign wake_evt  = kb_evt || EVT.mouse_wake || panel_evt;
    assign decide_off = off_decision(awpc_policy_t'(
                        control_reg[`AWPC_CT_POLICY_HI:`AWPC_CT_POLICY_LO]),
                        SYSTEM_WAS_ON, last_state_reg[`AWPC_LS_FLAG]);
    assign pulse_start = POWER_RETURN && decide_off &&
                         control_reg[`AWPC_CT_OFF_PULSE];

    ////////////////////////////////////////////////////////////////////////
    // The index only moves on an explicit write, so software can poll one byte.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            index_reg <= `AWPC_RST_KEY_INDEX;
        end else if (wr_index) begin
            index_reg <= WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < `AWPC_KEY_SETS*16; i++) begin
                key_mem_reg[i] <= `AWPC_RST_KEY_BYTE;
            end
        end else if (wr_data && (region != AWPC_REG_NONE) &&
                     (region != AWPC_REG_CAPTURE)) begin
            key_mem_reg[mem_addr(region, index_reg[3:0])] <= WDATA;
        end
    end

    // Oldest byte sits at slot 0 and the newest at the top slot.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < `AWPC_KEY_BYTES; i++) begin
                capture_reg[i] <= `AWPC_RST_KEY_BYTE;
            end
        end else if (KEY_VALID) begin
            for (int i = 0; i < `AWPC_KEY_BYTES - 1; i++) begin
                capture_reg[i] <= capture_reg[i+1];
            end
            capture_reg[`AWPC_KEY_BYTES-1] <= KEY_BYTE;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            key_seen_reg   <= 1'b0;
            panel_prev_reg <= 1'b0;
        end else begin
            key_seen_reg   <= KEY_VALID;
            panel_prev_reg <= EVT.panel_switch_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // An event in the same cycle as the clearing read survives that read.
    always_comb begin
        status_next = rd_status ? 8'h00 : status_reg;
        if (EVT.standby_cycled) begin
            status_next[`AWPC_ST_STANDBY] = 1'b1;
        end
        if (POWER_RETURN) begin
            status_next[`AWPC_ST_DECISION] = decide_off;
        end
        if (EVT.thermal) begin
            status_next[`AWPC_ST_THERMAL] = 1'b1;
        end
        if (panel_evt) begin
            status_next[`AWPC_ST_PANEL] = 1'b1;
        end
        if (EVT.mouse_wake) begin
            status_next[`AWPC_ST_MOUSE] = 1'b1;
        end
        if (kb_evt) begin
            status_next[`AWPC_ST_KEYBOARD] = 1'b1;
        end
        status_next[7:6] = 2'b00;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            status_reg <= `AWPC_RST_STATUS;
        end else begin
            status_reg <= status_next;
        end
    end

    // Host reset wins over a write; a captured wake wins over a write too.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            control_reg <= `AWPC_RST_CONTROL;
        end else begin
            if (WR && (ADDR == `AWPC_OFF_CONTROL)) begin
                control_reg <= WDATA & `AWPC_MASK_CONTROL;
            end
            if (wake_evt) begin
                control_reg[`AWPC_CT_HUNT] <= 1'b0;
            end
            if (!HOST_RST_N) begin
                control_reg[`AWPC_CT_ANY_KEY] <= 1'b0;
                control_reg[`AWPC_CT_HUNT]    <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            source_reg <= `AWPC_RST_SOURCE;
        end else if (WR && (ADDR == `AWPC_OFF_RST_SOURCE)) begin
            source_reg <= WDATA & `AWPC_MASK_SOURCE;
        end
    end

    // Only the power-on reset and a software write touch this flag, standing in for battery power.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            last_state_reg <= 8'h00;
        end else if (WR && (ADDR == `AWPC_OFF_LAST_STATE)) begin
            last_state_reg <= WDATA & `AWPC_MASK_LAST_STATE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        rd_value = 8'h00;
        if (ADDR == `AWPC_OFF_KEY_INDEX) begin
            rd_value = index_reg;
        end else if (ADDR == `AWPC_OFF_KEY_DATA) begin
            if (region == AWPC_REG_CAPTURE) begin
                rd_value = capture_reg[index_reg[3:0]];
            end else if (region == AWPC_REG_NONE) begin
                rd_value = `AWPC_RST_KEY_BYTE;
            end else begin
                rd_value = key_mem_reg[mem_addr(region, index_reg[3:0])];
            end
        end else if (ADDR == `AWPC_OFF_STATUS) begin
            rd_value = status_reg;
            rd_value[`AWPC_ST_DECISION] = status_reg[`AWPC_ST_DECISION] &&
                                          control_reg[`AWPC_CT_OFF_PULSE];
        end else if (ADDR == `AWPC_OFF_CONTROL) begin
            rd_value = control_reg;
        end else if (ADDR == `AWPC_OFF_RST_SOURCE) begin
            rd_value = source_reg;
        end else if (ADDR == `AWPC_OFF_LAST_STATE) begin
            rd_value = last_state_reg;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= RD ? rd_value : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // A new return restarts the count rather than stacking pulses.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pulse_cnt_reg <= '0;
        end else if (pulse_start) begin
            pulse_cnt_reg <= CW'(OFF_PULSE_CYCLES);
        end else if (pulse_cnt_reg != '0) begin
            pulse_cnt_reg <= pulse_cnt_reg - CW'(1);
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            power_switch_out_n_n_reg <= 1'b1;
            wake_reg    <= 1'b0;
        end else begin
            power_switch_out_n_n_reg <= !(pulse_start || (pulse_cnt_reg > CW'(1)) ||
                             EVT.panel_switch_in);
            wake_reg    <= wake_evt && control_reg[`AWPC_CT_HUNT];
        end
    end

    // Outputs are registered so a glitch on the inputs never reaches the chipset.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            gate_n_reg    <= 1'b1;
            pgood_reg     <= 1'b0;
            vid_rst_n_reg <= 1'b0;
            gpa_rst_n_reg <= 1'b0;
            gpb_rst_n_reg <= 1'b0;
        end else begin
            gate_n_reg    <= !(control_reg[`AWPC_CT_GATE_EN] && POWER_GOOD_IN);
            pgood_reg     <= POWER_GOOD_IN && (source_reg[`AWPC_RS_SUPPLY_DIS] ||
                             SUPPLY_GOOD_IN);
            vid_rst_n_reg <= source_reg[`AWPC_RS_VID] ? POWER_GOOD_IN : HOST_RST_N;
            gpb_rst_n_reg <= source_reg[`AWPC_RS_GPIO_B] ? POWER_GOOD_IN : HOST_RST_N;
            gpa_rst_n_reg <= source_reg[`AWPC_RS_GPIO_A] ? POWER_GOOD_IN : HOST_RST_N;
        end
    end

    assign RDATA                 = rdata_reg;
    assign POWER_SWITCH_OUT_N    = power_switch_out_n_n_reg;
    assign STANDBY_GATE_N        = gate_n_reg;
    assign POWER_GOOD_OUT        = pgood_reg;
    assign POWER_GOOD_OUT_SECOND = pgood_reg;
    assign VOLTAGE_ID_RST_N      = vid_rst_n_reg;
    assign GPIO_A_RST_N          = gpa_rst_n_reg;
    assign GPIO_B_RST_N          = gpb_rst_n_reg;
    assign WAKE_REQ              = wake_reg;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    index_hold_a: assert property (wr_data |=> $stable(index_reg))
        else $error("key index moved on a data access");
    capture_ro_a: assert property (wr_data && region == AWPC_REG_CAPTURE && !KEY_VALID
        |=> $stable(capture_reg[index_reg[3:0]]))
        else $error("capture byte changed by a write");
    capt_read_a: assert property (RD && ADDR == `AWPC_OFF_KEY_DATA &&
        region == AWPC_REG_CAPTURE |=> RDATA == $past(capture_reg[index_reg[3:0]]))
        else $error("capture window read wrong byte");
    set_write_a: assert property (wr_data && region == AWPC_REG_SET1 ##1
        RD && ADDR == `AWPC_OFF_KEY_DATA |=> RDATA == $past(WDATA, 2))
        else $error("stored key byte not read back");
    standby_flag_a: assert property (EVT.standby_cycled
        |=> status_reg[`AWPC_ST_STANDBY])
        else $error("standby flag lost");
    decision_gate_a: assert property (RD && ADDR == `AWPC_OFF_STATUS &&
        !control_reg[`AWPC_CT_OFF_PULSE] |=> !RDATA[`AWPC_ST_DECISION])
        else $error("decision bit visible while disabled");
    thermal_flag_a: assert property (EVT.thermal |=> status_reg[`AWPC_ST_THERMAL])
        else $error("thermal flag lost");
    read_clear_a: assert property (rd_status && !EVT.thermal && !panel_evt
        && !EVT.mouse_wake && !kb_evt |=> status_reg[3:0] == 4'h0)
        else $error("status not cleared by read");
    mouse_hold_a: assert property (status_reg[`AWPC_ST_MOUSE] && !rd_status
        |=> status_reg[`AWPC_ST_MOUSE])
        else $error("mouse flag dropped before read");
    kb_flag_a: assert property (kb_evt |=> status_reg[`AWPC_ST_KEYBOARD])
        else $error("keyboard flag lost");
    off_pulse_a: assert property (pulse_start |=> !POWER_SWITCH_OUT_N &&
        pulse_cnt_reg == CW'(OFF_PULSE_CYCLES))
        else $error("off pulse not started");
    policy_on_a: assert property (control_reg[6:5] == 2'b01 |-> !decide_off)
        else $error("policy on decided off");
    user_flag_a: assert property (control_reg[6:5] == 2'b11
        |-> decide_off == last_state_reg[`AWPC_LS_FLAG])
        else $error("user last state ignored");
    gate_out_a: assert property (!control_reg[`AWPC_CT_GATE_EN] |=> STANDBY_GATE_N)
        else $error("standby gate driven while disabled");
    host_clear_a: assert property (!HOST_RST_N |=> !control_reg[`AWPC_CT_ANY_KEY])
        else $error("any-key bit survived host reset");
    hunt_clear_a: assert property (wake_evt |=> !control_reg[`AWPC_CT_HUNT])
        else $error("hunting not cleared by wake");
    vid_src_a: assert property (source_reg[`AWPC_RS_VID]
        |=> VOLTAGE_ID_RST_N == $past(POWER_GOOD_IN))
        else $error("voltage-id reset source wrong");
    supply_gate_a: assert property (!source_reg[`AWPC_RS_SUPPLY_DIS] && !SUPPLY_GOOD_IN
        |=> !POWER_GOOD_OUT && !POWER_GOOD_OUT_SECOND)
        else $error("power good passed without supply good");

    pulse_run_c: cover property (pulse_start ##1 !POWER_SWITCH_OUT_N [*4]);
    kb_wake_c: cover property (control_reg[`AWPC_CT_HUNT] && kb_evt ##1 WAKE_REQ);
    clear_race_c: cover property (rd_status && EVT.thermal);
    capt_read_c: cover property (KEY_VALID ##2 RD && ADDR == `AWPC_OFF_KEY_DATA);

endmodule

// >>> dv/awpc_supply_model.sv
// Supply and chipset model: power good follows its request one cycle late, as a real
// supply never answers in the same cycle. It also measures each low run of the switch.
module awpc_supply_model (
    input  wire logic clk,
    input  wire logic supply_en,
    input  wire logic pg_en,
    input  wire logic switch_n,
    output logic      supply_good,
    output logic      power_good,
    output int        last_low
);
    timeunit 1ns;
    timeprecision 1ns;
    int run;
    assign supply_good = supply_en;
    always_ff @(posedge clk) begin
        power_good <= pg_en;
        if (!switch_n) begin
            run <= run + 1;
        end else begin
            if (run != 0) last_low <= run;
            run <= 0;
        end
    end
endmodule

// >>> dv/testbench.sv
module testbench import awpc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PULSE = 8;
    logic       clk, rst_n, host_rst_n, wr, rd, key_valid, pwr_ret, was_on, sup_en, pg_en;
    logic [7:0] addr, wdata, rdata, key_byte;
    awpc_evt_t  evt;
    logic       sw_n, gate_n, pg_out, pg_out2, vid_n, ga_n, gb_n, wake, sup_good, pg_in;
    int         miscompares, checks_done, last_low, cycles;
    awpc_ctrl #(.OFF_PULSE_CYCLES(PULSE)) dut_u (
        .CLK(clk), .RST_N(rst_n), .HOST_RST_N(host_rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .KEY_VALID(key_valid), .KEY_BYTE(key_byte),
        .EVT(evt), .POWER_RETURN(pwr_ret), .SYSTEM_WAS_ON(was_on),
        .SUPPLY_GOOD_IN(sup_good), .POWER_GOOD_IN(pg_in), .POWER_SWITCH_OUT_N(sw_n),
        .STANDBY_GATE_N(gate_n), .POWER_GOOD_OUT(pg_out), .POWER_GOOD_OUT_SECOND(pg_out2),
        .VOLTAGE_ID_RST_N(vid_n), .GPIO_A_RST_N(ga_n), .GPIO_B_RST_N(gb_n), .WAKE_REQ(wake));
    awpc_supply_model model_u (
        .clk(clk), .supply_en(sup_en), .pg_en(pg_en), .switch_n(sw_n),
        .supply_good(sup_good), .power_good(pg_in), .last_low(last_low));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), e, rdata);
    endtask
    // Write then read back with no idle cycle between the two strobes.
    task automatic wr_rd(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), d, rdata);
    endtask
    task automatic fire(awpc_evt_t e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= '0;
    endtask
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_reg(8'he1, 8'h00);
        rd_reg(8'he2, 8'hff);
        rd_reg(8'he3, 8'h08);
        rd_reg(8'he4, 8'h00);
        rd_reg(8'he5, 8'h00);
        rd_reg(8'he7, 8'h00);
    endtask
    task automatic t_keys();
        wr_reg(8'he1, 8'h31);
        wr_rd(8'he2, 8'haa);
        wr_reg(8'he1, 8'h4e);
        wr_reg(8'he2, 8'h55);
        wr_reg(8'he1, 8'h0e);
        wr_reg(8'he2, 8'h33);
        rd_reg(8'he1, 8'h0e);
        rd_reg(8'he2, 8'h33);
        wr_reg(8'he1, 8'h31);
        rd_reg(8'he2, 8'haa);
        wr_reg(8'he1, 8'h4e);
        rd_reg(8'he2, 8'h55);
        wr_reg(8'he1, 8'h15);
        wr_reg(8'he2, 8'h00);
        rd_reg(8'he2, 8'hff);
    endtask
    task automatic t_events();
        fire(4'b1000);
        fire(4'b0100);
        fire(4'b0010);
        fire(4'b0001);
        settle(2);
        rd_reg(8'he3, 8'h2e);
        rd_reg(8'he3, 8'h00);
    endtask
    task automatic t_kbd();
        wr_reg(8'he4, 8'h0c);
        @(posedge clk);
        key_byte <= 8'h5a;
        key_valid <= 1'b1;
        @(posedge clk);
        key_valid <= 1'b0;
        for (int i = 0; i < 10 && wake !== 1'b1; i++) settle(1);
        chk("wake_req", 8'h01, {7'h00, wake});
        settle(2);
        rd_reg(8'he3, 8'h01);
        rd_reg(8'he4, 8'h08);
        wr_reg(8'he1, 8'h1e);
        rd_reg(8'he2, 8'h5a);
        wr_reg(8'he4, 8'h1c);
        host_rst_n <= 1'b0;
        settle(2);
        host_rst_n <= 1'b1;
        rd_reg(8'he4, 8'h10);
        pg_en <= 1'b1;
        settle(4);
        chk("standby_gate_n", 8'h00, {7'h00, gate_n});
        wr_reg(8'he4, 8'h00);
        settle(3);
        chk("standby_gate_n", 8'h01, {7'h00, gate_n});
    endtask
    // Policy 10 sees the system as on before the loss, so only 00 and 11 decide off.
    task automatic t_loss();
        logic off;
        wr_reg(8'he6, 8'h10);
        was_on <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            off = (p == 0) || (p == 3);
            wr_reg(8'he4, {1'b1, 2'(p), 5'h00});
            @(posedge clk);
            pwr_ret <= 1'b1;
            @(posedge clk);
            pwr_ret <= 1'b0;
            #1;
            chk("switch_n", {7'h00, !off}, {7'h00, sw_n});
            settle(PULSE + 4);
            rd_reg(8'he3, {3'h0, off, 4'h0});
            if (off) chk("off_pulse_len", 8'(PULSE), 8'(last_low));
        end
        wr_reg(8'he4, 8'h00);
        @(posedge clk);
        pwr_ret <= 1'b1;
        @(posedge clk);
        pwr_ret <= 1'b0;
        rd_reg(8'he3, 8'h00);
    endtask
    task automatic t_src();
        wr_reg(8'he5, 8'h00);
        settle(3);
        chk("power_good_out", 8'h00, {7'h00, pg_out});
        sup_en <= 1'b1;
        settle(3);
        chk("power_good_outs", 8'h03, {6'h00, pg_out, pg_out2});
        sup_en <= 1'b0;
        wr_reg(8'he5, 8'h01);
        settle(3);
        chk("power_good_outs", 8'h03, {6'h00, pg_out, pg_out2});
        wr_reg(8'he5, 8'h1d);
        pg_en <= 1'b0;
        settle(4);
        chk("reset_outs", 8'h00, {5'h00, vid_n, gb_n, ga_n});
        wr_reg(8'he5, 8'h08);
        settle(3);
        chk("reset_outs", 8'h05, {5'h00, vid_n, gb_n, ga_n});
        wr_reg(8'he5, 8'h04);
        settle(3);
        chk("reset_outs", 8'h06, {5'h00, vid_n, gb_n, ga_n});
        wr_reg(8'he5, 8'h01);
        settle(3);
        chk("reset_outs", 8'h07, {5'h00, vid_n, gb_n, ga_n});
        rd_reg(8'he5, 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        {rst_n, wr, rd, key_valid, pwr_ret, was_on, sup_en, pg_en} = '0;
        host_rst_n = 1'b1;
        {addr, wdata, key_byte} = '0;
        evt = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_keys();
        t_events();
        t_kbd();
        t_loss();
        t_src();
        test_done();
    end
endmodule
